// ### pkg/gdl_pkg.sv
// Package for the gate drive init and lockout block: timing counts and state codes.
// Assumes a 200 MHz sys_clk shared by the device end and the host end.
`default_nettype none
package gdl_pkg;
    localparam int CLK_PERIOD_NS = 5;
    // Host-side timing, each figure in its own unit, with cycle counts derived from it.
    localparam int STANDBY_EXIT_NS = 280;
    localparam int STANDBY_EXIT_CYC = (STANDBY_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIRST_LS_ON_NS = 1000;
    localparam int FIRST_LS_ON_CYC = (FIRST_LS_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_LS_ON_NS = 100;
    localparam int RECOVER_LS_ON_CYC = (RECOVER_LS_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HS_EXTRA_NS = 100;
    localparam int HS_EXTRA_CYC = (HS_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPI_TO_ENABLE_NS = 0;
    localparam int SPI_TO_ENABLE_CYC = (SPI_TO_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_MS = 2;
    localparam int SETTLE_CYC = SETTLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 20;
    localparam int NPH = 3;
    // Per-phase arming state.
    typedef enum logic [1:0] {
        GDL_UNARMED = 2'b00,
        GDL_ARMED = 2'b01,
        GDL_HS_ON_SEEN = 2'b10,
        GDL_LATCHED = 2'b11
    } gdl_phase_e;
    // Host sequencer states.
    typedef enum logic [2:0] {
        GDL_H_SETTLE = 3'b000,
        GDL_H_CONFIG = 3'b001,
        GDL_H_EN_WAIT = 3'b010,
        GDL_H_LS_ON = 3'b011,
        GDL_H_HS_ON = 3'b100,
        GDL_H_RUN = 3'b101
    } gdl_host_e;
endpackage
`default_nettype wire

// ### pkg/gdl_link_if.sv
// Interface joining the host controller end to the gate drive logic end.
// Assumes one clock; all signals are levels sampled on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface gdl_link_if;
    logic gate_enable_a_pin;
    logic gate_enable_b_pin;
    logic [2:0] low_side_in;
    logic [2:0] high_side_in_n;
    logic clear_flags_cmd_0;
    // Host drives enables, phase inputs and flag clear.
    modport host (output gate_enable_a_pin, gate_enable_b_pin, low_side_in, high_side_in_n, clear_flags_cmd_0);
    // Device receives them.
    modport dev (input gate_enable_a_pin, gate_enable_b_pin, low_side_in, high_side_in_n, clear_flags_cmd_0);
endinterface
`default_nettype wire

// ### design/gdl_device.sv
// Gate drive output-state and lockout logic of a three-phase pre-driver.
// Assumes the host end on gdl_link_if.dev and supply status inputs synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module gdl_device (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Link from the host.
    gdl_link_if.dev link,
    // Supply and fault status.
    input wire logic gate_supply_rail_ok,
    input wire logic logic_supply_ok,
    input wire logic power_on_reset,
    input wire logic fault_in,
    // Gate drive outputs.
    output logic [2:0] low_gate_out,
    output logic [2:0] upper_gate_out,
    output logic [2:0] low_gate_hiz,
    output logic [2:0] upper_gate_hiz,
    output logic [2:0] upper_gate_state,
    // Status.
    output logic standby_state,
    output logic fault_flag
);
    logic hold_off;
    logic enabled;
    logic [2:0] ls_prev_r;
    logic [2:0] ls_prev_nxt;
    logic [2:0] hs_prev_r;
    logic [2:0] hs_prev_nxt;
    logic [2:0] low_gate_nxt;
    logic [2:0] upper_gate_nxt;
    logic [2:0] low_hiz_nxt;
    logic [2:0] upper_hiz_nxt;
    logic standby_nxt;
    logic fault_flag_r;
    logic fault_flag_nxt;
    gdl_pkg::gdl_phase_e st_r [gdl_pkg::NPH];
    gdl_pkg::gdl_phase_e st_nxt [gdl_pkg::NPH];

    // --------------------------------------------------------------
    // Global conditions
    // --------------------------------------------------------------
    // Hold-off forces every gate low while any supply is bad.
    assign hold_off = !gate_supply_rail_ok || !logic_supply_ok || power_on_reset;
    // Phase inputs count only when both enables are high and no fault.
    assign enabled = link.gate_enable_a_pin && link.gate_enable_b_pin && !fault_in;
    assign upper_gate_state = upper_gate_out;
    assign fault_flag = fault_flag_r;

    // Fault flag sets while a fault or hold-off persists and clears only on a command.
    always_comb begin
        fault_flag_nxt = fault_flag_r;
        if (link.clear_flags_cmd_0) begin
            fault_flag_nxt = 1'b0;
        end
        if (fault_in || hold_off) begin
            fault_flag_nxt = 1'b1;
        end
    end

    // Standby shown whenever the enables are not both high.
    always_comb begin
        standby_nxt = !(link.gate_enable_a_pin && link.gate_enable_b_pin);
    end

    // --------------------------------------------------------------
    // Per-phase arming and gate drive
    // --------------------------------------------------------------
    for (genvar p = 0; p < gdl_pkg::NPH; p++) begin : g_phase
        logic ls_rise;
        logic ls_fall;
        logic hs_on_edge;
        logic hs_off_edge;
        // Edge detection on the phase inputs.
        assign ls_rise = link.low_side_in[p] && !ls_prev_r[p];
        assign ls_fall = !link.low_side_in[p] && ls_prev_r[p];
        assign hs_on_edge = !link.high_side_in_n[p] && hs_prev_r[p];
        assign hs_off_edge = link.high_side_in_n[p] && !hs_prev_r[p];

        // Next state and gate levels for one phase.
        always_comb begin
            st_nxt[p] = st_r[p];
            low_gate_nxt[p] = low_gate_out[p];
            upper_gate_nxt[p] = upper_gate_out[p];
            low_hiz_nxt[p] = low_gate_hiz[p];
            upper_hiz_nxt[p] = upper_gate_hiz[p];
            ls_prev_nxt[p] = link.low_side_in[p];
            hs_prev_nxt[p] = link.high_side_in_n[p];
            if (hold_off) begin
                st_nxt[p] = gdl_pkg::GDL_UNARMED;
                low_gate_nxt[p] = 1'b0;
                upper_gate_nxt[p] = 1'b0;
            end else if (!enabled) begin
                // Standby or fault: drive low and lock the high side.
                if (st_r[p] != gdl_pkg::GDL_UNARMED || !upper_gate_hiz[p]) begin
                    low_gate_nxt[p] = 1'b0;
                    upper_gate_nxt[p] = 1'b0;
                    low_hiz_nxt[p] = 1'b0;
                end
                st_nxt[p] = gdl_pkg::GDL_UNARMED;
            end else begin
                // Low side follows its input once a command arrives.
                if (ls_rise || ls_fall || !low_gate_hiz[p]) begin
                    low_hiz_nxt[p] = 1'b0;
                    low_gate_nxt[p] = link.low_side_in[p] && !upper_gate_out[p];
                end
                case (st_r[p])
                    gdl_pkg::GDL_UNARMED: begin
                        if (ls_rise) begin
                            st_nxt[p] = gdl_pkg::GDL_ARMED;
                        end
                    end
                    gdl_pkg::GDL_ARMED: begin
                        if (hs_on_edge && !link.low_side_in[p]) begin
                            st_nxt[p] = gdl_pkg::GDL_HS_ON_SEEN;
                            upper_hiz_nxt[p] = 1'b0;
                            upper_gate_nxt[p] = 1'b1;
                        end
                    end
                    gdl_pkg::GDL_HS_ON_SEEN: begin
                        if (hs_off_edge) begin
                            st_nxt[p] = gdl_pkg::GDL_LATCHED;
                            upper_gate_nxt[p] = 1'b0;
                        end
                    end
                    gdl_pkg::GDL_LATCHED: begin
                        // Normal operation: follow the inputs, low impedance.
                        upper_hiz_nxt[p] = 1'b0;
                        upper_gate_nxt[p] = !link.high_side_in_n[p] && !link.low_side_in[p];
                        low_gate_nxt[p] = link.low_side_in[p] && link.high_side_in_n[p];
                    end
                    default: begin
                        st_nxt[p] = gdl_pkg::GDL_UNARMED;
                    end
                endcase
            end
        end

        // Phase registers.
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                st_r[p] <= gdl_pkg::GDL_UNARMED;
                low_gate_out[p] <= 1'b0;
                upper_gate_out[p] <= 1'b0;
                low_gate_hiz[p] <= 1'b1;
                upper_gate_hiz[p] <= 1'b1;
                ls_prev_r[p] <= 1'b0;
                hs_prev_r[p] <= 1'b1;
            end else begin
                st_r[p] <= st_nxt[p];
                low_gate_out[p] <= low_gate_nxt[p];
                upper_gate_out[p] <= upper_gate_nxt[p];
                low_gate_hiz[p] <= low_hiz_nxt[p];
                upper_gate_hiz[p] <= upper_hiz_nxt[p];
                ls_prev_r[p] <= ls_prev_nxt[p];
                hs_prev_r[p] <= hs_prev_nxt[p];
            end
        end
    end

    // Status registers.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            standby_state <= 1'b1;
            fault_flag_r <= 1'b1;
        end else begin
            standby_state <= standby_nxt;
            fault_flag_r <= fault_flag_nxt;
        end
    end
endmodule
`default_nettype wire

// ### design/gdl_host.sv
// Host end: sequences reset recovery and standby recovery, then passes user phase commands.
// Assumes the device end on gdl_link_if.host and a 200 MHz sys_clk.
`timescale 1ns/1ps
`default_nettype none
module gdl_host #(
    parameter int SETTLE_CYCLES = gdl_pkg::SETTLE_CYC,
    parameter int DEADTIME_CYCLES = 255
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Link to the device.
    gdl_link_if.host link,
    // User side.
    input wire logic config_done,
    input wire logic run_enable,
    input wire logic [2:0] user_low_side,
    input wire logic [2:0] user_high_side_n,
    output logic ready
);
    gdl_pkg::gdl_host_e st_r;
    gdl_pkg::gdl_host_e st_nxt;
    logic [gdl_pkg::CNT_W-1:0] cnt_r;
    logic [gdl_pkg::CNT_W-1:0] cnt_nxt;
    logic first_r;
    logic first_nxt;
    logic en_nxt;
    logic clr_nxt;
    logic [2:0] ls_nxt;
    logic [2:0] hs_nxt;
    logic [gdl_pkg::CNT_W-1:0] ls_len;

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    // First pulse after reset is long; recovery pulses may be short.
    assign ls_len = first_r ? gdl_pkg::CNT_W'(gdl_pkg::FIRST_LS_ON_CYC) : gdl_pkg::CNT_W'(gdl_pkg::RECOVER_LS_ON_CYC);
    assign ready = (st_r == gdl_pkg::GDL_H_RUN);

    // Next state and link outputs.
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r + 1'b1;
        first_nxt = first_r;
        en_nxt = link.gate_enable_a_pin;
        clr_nxt = 1'b0;
        ls_nxt = link.low_side_in;
        hs_nxt = link.high_side_in_n;
        case (st_r)
            gdl_pkg::GDL_H_SETTLE: begin
                if (cnt_r >= gdl_pkg::CNT_W'(SETTLE_CYCLES)) begin
                    st_nxt = gdl_pkg::GDL_H_CONFIG;
                end
            end
            gdl_pkg::GDL_H_CONFIG: begin
                en_nxt = 1'b0;
                ls_nxt = 3'h0;
                hs_nxt = 3'h7;
                if (config_done && run_enable) begin
                    clr_nxt = 1'b1;
                    en_nxt = 1'b1;
                    cnt_nxt = '0;
                    st_nxt = gdl_pkg::GDL_H_EN_WAIT;
                end
            end
            gdl_pkg::GDL_H_EN_WAIT: begin
                if (cnt_r >= gdl_pkg::CNT_W'(gdl_pkg::STANDBY_EXIT_CYC)) begin
                    ls_nxt = 3'h7;
                    cnt_nxt = '0;
                    st_nxt = gdl_pkg::GDL_H_LS_ON;
                end
            end
            gdl_pkg::GDL_H_LS_ON: begin
                if (cnt_r >= ls_len) begin
                    ls_nxt = 3'h0;
                    hs_nxt = 3'h0;
                    cnt_nxt = '0;
                    st_nxt = gdl_pkg::GDL_H_HS_ON;
                end
            end
            gdl_pkg::GDL_H_HS_ON: begin
                if (cnt_r >= gdl_pkg::CNT_W'(DEADTIME_CYCLES + gdl_pkg::HS_EXTRA_CYC)) begin
                    hs_nxt = 3'h7;
                    first_nxt = 1'b0;
                    st_nxt = gdl_pkg::GDL_H_RUN;
                end
            end
            gdl_pkg::GDL_H_RUN: begin
                cnt_nxt = cnt_r;
                ls_nxt = user_low_side;
                hs_nxt = user_high_side_n;
                if (!run_enable) begin
                    en_nxt = 1'b0;
                    ls_nxt = 3'h0;
                    hs_nxt = 3'h7;
                    st_nxt = gdl_pkg::GDL_H_CONFIG;
                end
            end
            default: begin
                st_nxt = gdl_pkg::GDL_H_SETTLE;
            end
        endcase
    end

    // Sequencer registers and link drivers.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= gdl_pkg::GDL_H_SETTLE;
            cnt_r <= '0;
            first_r <= 1'b1;
            link.gate_enable_a_pin <= 1'b0;
            link.gate_enable_b_pin <= 1'b0;
            link.clear_flags_cmd_0 <= 1'b0;
            link.low_side_in <= 3'h0;
            link.high_side_in_n <= 3'h7;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            first_r <= first_nxt;
            link.gate_enable_a_pin <= en_nxt;
            link.gate_enable_b_pin <= en_nxt;
            link.clear_flags_cmd_0 <= clr_nxt;
            link.low_side_in <= ls_nxt;
            link.high_side_in_n <= hs_nxt;
        end
    end
endmodule
`default_nettype wire

// ### test/gdl_link_checker.sv
// Checker for the host end of the gate drive link; it watches the interface wires only.
// Assumes one sys_clk domain, a synchronous active-high reset and a testbench instance beside the link.
`timescale 1ns/1ps
`default_nettype none
module gdl_link_checker #(
    parameter int SETTLE_CYCLES = 20,
    parameter int DEADTIME_CYCLES = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Link wires.
    input wire logic gate_enable_a_pin,
    input wire logic gate_enable_b_pin,
    input wire logic [2:0] low_side_in,
    input wire logic [2:0] high_side_in_n,
    input wire logic clear_flags_cmd_0
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic en_both, first_r, first_nxt;
    logic [2:0] seen_r, seen_nxt, ls_q_r, hs_q_r;
    logic [15:0] rel_cnt_r, rel_cnt_nxt, en_cnt_r, en_cnt_nxt, ls_cnt_r, ls_cnt_nxt, hs_cnt_r, hs_cnt_nxt;

    // Saturating increment, so long runs never wrap a count back to zero.
    function automatic logic [15:0] inc16(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h1;
    endfunction

    // Counts time since reset, enable time, init pulse lengths and which low sides rose.
    always_comb begin
        en_both = gate_enable_a_pin & gate_enable_b_pin;
        rel_cnt_nxt = inc16(rel_cnt_r);
        en_cnt_nxt = en_both ? inc16(en_cnt_r) : 16'h0;
        ls_cnt_nxt = (en_both && low_side_in == 3'h7 && high_side_in_n == 3'h7) ? inc16(ls_cnt_r) : 16'h0;
        hs_cnt_nxt = (high_side_in_n == 3'h0) ? inc16(hs_cnt_r) : 16'h0;
        seen_nxt = en_both ? (seen_r | (low_side_in & ~ls_q_r)) : 3'h0;
        first_nxt = first_r & ~(ls_cnt_r != 16'h0 && low_side_in != 3'h7);
    end

    // Registers the helper state.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            {rel_cnt_r, en_cnt_r, ls_cnt_r, hs_cnt_r} <= '0;
            seen_r <= 3'h0;
            first_r <= 1'b1;
            ls_q_r <= 3'h0;
            hs_q_r <= 3'h7;
        end else begin
            {rel_cnt_r, en_cnt_r, ls_cnt_r, hs_cnt_r} <= {rel_cnt_nxt, en_cnt_nxt, ls_cnt_nxt, hs_cnt_nxt};
            seen_r <= seen_nxt;
            first_r <= first_nxt;
            ls_q_r <= low_side_in;
            hs_q_r <= high_side_in_n;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_settle_hold; (rel_cnt_r < SETTLE_CYCLES) |-> !gate_enable_a_pin && !gate_enable_b_pin; endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("enable raised before settle time");
    property p_clear_first; $rose(en_both) |-> clear_flags_cmd_0 || $past(clear_flags_cmd_0); endproperty
    a_clear_first: assert property (p_clear_first) else $error("enables rose without flag clear");
    property p_en_pair; gate_enable_a_pin == gate_enable_b_pin; endproperty
    a_en_pair: assert property (p_en_pair) else $error("enables differ");
    property p_standby_exit; (|(low_side_in & ~ls_q_r)) |-> en_cnt_r >= gdl_pkg::STANDBY_EXIT_CYC; endproperty
    a_standby_exit: assert property (p_standby_exit) else $error("low side rose too soon after enables");
    property p_first_pulse; (first_r && ls_cnt_r != 16'h0 && low_side_in != 3'h7) |->
        ls_cnt_r >= gdl_pkg::FIRST_LS_ON_CYC; endproperty
    a_first_pulse: assert property (p_first_pulse) else $error("first low pulse too short");
    property p_recover_pulse; (!first_r && ls_cnt_r != 16'h0 && low_side_in != 3'h7) |->
        ls_cnt_r >= gdl_pkg::RECOVER_LS_ON_CYC; endproperty
    a_recover_pulse: assert property (p_recover_pulse) else $error("recovery low pulse too short");
    property p_hs_length; (hs_cnt_r != 16'h0 && high_side_in_n != 3'h0) |->
        hs_cnt_r >= DEADTIME_CYCLES + gdl_pkg::HS_EXTRA_CYC; endproperty
    a_hs_length: assert property (p_hs_length) else $error("high side on pulse too short");
    property p_hs_order; en_both |-> (~high_side_in_n & hs_q_r & ~seen_r) == 3'h0; endproperty
    a_hs_order: assert property (p_hs_order) else $error("high side edge before low side toggle");
endmodule
`default_nettype wire

// ### test/test_gate_drive_init_lockout.sv
// Testbench: host and device ends joined on one link, a second device driven directly by the bench.
// Assumes the design package, link interface and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_gate_drive_init_lockout;
    localparam int DT = 4;
    logic sys_clk = 1'b0, reset = 1'b1, config_done = 1'b0, run_enable = 1'b0, ready;
    logic rail_ok = 1'b1, logic_ok = 1'b1, por = 1'b0, fault = 1'b0, sb_a, ff_a, sb_b, ff_b;
    logic [2:0] user_ls = 3'h0, user_hs_n = 3'h7, lo_a, up_a, lhz_a, uhz_a, st_a, lo_b, up_b, lhz_b, uhz_b, st_b;
    logic [15:0] rows [6] = '{16'h1710, 16'h0601, 16'h4300, 16'h0106, 16'h2720, 16'h0700};
    int error_cnt = 0, compares = 0, cycles = 0;

    // ----------------------------------------
    // Clock, link and design ends
    // ----------------------------------------
    always #2.5 sys_clk = ~sys_clk;
    gdl_link_if link();
    gdl_link_if link_b();
    gdl_host #(.SETTLE_CYCLES(20), .DEADTIME_CYCLES(DT)) u_gdl_host (.sys_clk(sys_clk), .reset(reset), .link(link),
        .config_done(config_done), .run_enable(run_enable), .user_low_side(user_ls), .user_high_side_n(user_hs_n),
        .ready(ready));
    gdl_device u_gdl_device (.sys_clk(sys_clk), .reset(reset), .link(link), .gate_supply_rail_ok(rail_ok),
        .logic_supply_ok(logic_ok), .power_on_reset(por), .fault_in(fault), .low_gate_out(lo_a),
        .upper_gate_out(up_a), .low_gate_hiz(lhz_a), .upper_gate_hiz(uhz_a), .upper_gate_state(st_a),
        .standby_state(sb_a), .fault_flag(ff_a));
    gdl_device u_gdl_device_b (.sys_clk(sys_clk), .reset(reset), .link(link_b), .gate_supply_rail_ok(rail_ok),
        .logic_supply_ok(logic_ok), .power_on_reset(por), .fault_in(fault), .low_gate_out(lo_b),
        .upper_gate_out(up_b), .low_gate_hiz(lhz_b), .upper_gate_hiz(uhz_b), .upper_gate_state(st_b),
        .standby_state(sb_b), .fault_flag(ff_b));
    gdl_link_checker #(.SETTLE_CYCLES(20), .DEADTIME_CYCLES(DT)) u_gdl_link_checker (.sys_clk(sys_clk),
        .reset(reset), .gate_enable_a_pin(link.gate_enable_a_pin), .gate_enable_b_pin(link.gate_enable_b_pin),
        .low_side_in(link.low_side_in), .high_side_in_n(link.high_side_in_n),
        .clear_flags_cmd_0(link.clear_flags_cmd_0));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Waits n falling edges; all stimulus changes right after one.
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Waits for the host to report the run state, under a bound.
    task automatic wait_ready();
        for (int i = 0; i < 3000 && ready !== 1'b1; i++) tick(1);
        `CHK("ready", 1'b1, ready)
    endtask

    // Applies one table row and compares the gate levels once settled.
    task automatic check_row(input logic [15:0] r);
        user_ls = r[14:12];
        user_hs_n = r[10:8];
        tick(4);
        `CHK("gates", {r[6:4], r[2:0], r[2:0]}, {lo_a, up_a, st_a})
    endtask

    // Drives the directly driven link: both enables, low sides and high sides.
    task automatic drive_b(input logic en, input logic [2:0] ls, input logic [2:0] hs);
        link_b.gate_enable_a_pin = en;
        link_b.gate_enable_b_pin = en;
        link_b.low_side_in = ls;
        link_b.high_side_in_n = hs;
        tick(3);
    endtask

    // Cuts a hung run short.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        link_b.clear_flags_cmd_0 = 1'b0;
        link_b.gate_enable_a_pin = 1'b0;
        link_b.gate_enable_b_pin = 1'b0;
        link_b.low_side_in = 3'h0;
        link_b.high_side_in_n = 3'h7;
        tick(8);
        reset = 1'b0;
        `CHK("hiz", 6'h3f, {lhz_a, uhz_a})
        `CHK("reset outputs", 8'h03, {lo_a, up_a, sb_a, ff_a})
        config_done = 1'b1;
        run_enable = 1'b1;
        wait_ready();
        tick(2);
        `CHK("hiz run", 6'h00, {lhz_a, uhz_a})
        `CHK("standby flag", 2'h0, {sb_a, ff_a})
        foreach (rows[i]) check_row(rows[i]);
        // Each hold-off source and the fault input in turn, then recovery.
        for (int k = 0; k < 4; k++) begin
            user_ls = 3'h0;
            user_hs_n = 3'h7;
            {rail_ok, logic_ok, por, fault} = {k != 0, k != 1, k == 2, k == 3};
            tick(3);
            `CHK("gates off", 7'h01, {lo_a, up_a, ff_a})
            {rail_ok, logic_ok, por, fault} = 4'hc;
            user_hs_n = 3'h6;
            tick(3);
            `CHK("locked high", 4'h1, {up_a, ff_a})
            user_hs_n = 3'h7;
            run_enable = 1'b0;
            tick(2);
            run_enable = 1'b1;
            wait_ready();
            tick(2);
            `CHK("flag cleared", 1'b0, ff_a)
            check_row(rows[1]);
        end
        // Direct link: ignored while disabled, wrong order, then a correct init.
        drive_b(1'b0, 3'h7, 3'h7);
        `CHK("disabled low", 4'h1, {lo_b, sb_b})
        drive_b(1'b0, 3'h0, 3'h7);
        drive_b(1'b1, 3'h0, 3'h7);
        tick(60);
        drive_b(1'b1, 3'h0, 3'h6);
        `CHK("early high", 6'h07, {up_b, uhz_b})
        drive_b(1'b1, 3'h0, 3'h7);
        drive_b(1'b1, 3'h1, 3'h7);
        `CHK("low on", 3'h1, lo_b)
        drive_b(1'b1, 3'h0, 3'h7);
        drive_b(1'b1, 3'h0, 3'h6);
        `CHK("armed high", 6'h0e, {up_b, uhz_b})
        drive_b(1'b1, 3'h0, 3'h7);
        `CHK("latched off", 7'h0c, {up_b, uhz_b, lhz_b[0]})
        drive_b(1'b1, 3'h0, 3'h6);
        `CHK("follows", 6'h09, {up_b, st_b})
        // Flag clear on the direct link, then a fault and a clear in the same cycle.
        link_b.clear_flags_cmd_0 = 1'b1;
        tick(1);
        link_b.clear_flags_cmd_0 = 1'b0;
        tick(2);
        `CHK("flag clear", 1'b0, ff_b)
        fault = 1'b1;
        link_b.clear_flags_cmd_0 = 1'b1;
        tick(1);
        fault = 1'b0;
        link_b.clear_flags_cmd_0 = 1'b0;
        tick(2);
        `CHK("set wins", 1'b1, ff_b)
        // Reset in mid-run: both devices back to high impedance, then a full init again.
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        `CHK("hiz again", 12'hfff, {lhz_a, uhz_a, lhz_b, uhz_b})
        `CHK("reset outputs again", 8'h03, {lo_a, up_a, sb_a, ff_a})
        wait_ready();
        check_row(rows[1]);
        print_verdict();
    end
endmodule
`default_nettype wire
